// [hdl/cofc_config_regs.sv]
// cofc_config_regs: output format registers for outputs 3, 4, 5 and alarm reference select
// assumes a byte register port on the same clock, write strobe one cycle per write
`timescale 1ns/100ps

// How it works
// - register 6 bits 5:3 pick output 4 format or disable it
// - format codes: 1 off, 2 cmos, 3 low lvds, 5 lvpecl, 6 cml, 7 lvds
// - register 6 bits 2:0 pick output 3 format or disable it
// - register 7 bits 5:3 pick output 5 format or disable it
// - register 7 bits 2:0 pick the offset alarm reference, 0 external, 1-4 inputs
// - reset loads 0x2c into register 6 and 0x2a into register 7
module cofc_config_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // output 3 format
  output cofc_pkg::cofc_format_type o_out3_format,
  output logic o_out3_enabled,
  // output 4 format
  output cofc_pkg::cofc_format_type o_out4_format,
  output logic o_out4_enabled,
  // output 5 format
  output cofc_pkg::cofc_format_type o_out5_format,
  output logic o_out5_enabled,
  // offset alarm reference
  output logic [2:0] o_offset_alarm_ref_sel,
  output logic o_ref_external,
  output logic [3:0] o_ref_input,
  output logic o_ref_reserved,
  // raw fields and high-power count
  output logic [2:0] o_out3_format_sel,
  output logic [2:0] o_out4_format_sel,
  output logic [2:0] o_out5_format_sel,
  output logic [1:0] o_high_power_count
);
  // register contents and their next values
  logic [7:0] output_format_three_four;
  logic [7:0] output_five_format_and_alarm_ref;
  logic [7:0] next_output_format_three_four;
  logic [7:0] next_output_five_format_and_alarm_ref;
  logic [7:0] next_rdata;
  // address hits
  logic hit_three_four;
  logic hit_five_ref;
  // field codes
  logic [2:0] out3_code;
  logic [2:0] out4_code;
  logic [2:0] out5_code;
  logic [2:0] ref_code;
  // decoded helpers
  logic out3_hp;
  logic out4_hp;
  logic out5_hp;
  logic [4:0] next_ref_onehot;
  logic [1:0] next_high_power_count;

  // low or high three-bit field of a register
  function automatic logic [2:0] field_at(input logic [7:0] value, input logic high);
    field_at = high ? value[cofc_pkg::HIGH_FIELD_LSB +: cofc_pkg::FIELD_W]
                    : value[cofc_pkg::LOW_FIELD_LSB +: cofc_pkg::FIELD_W];
  endfunction

  // address compare against one register offset
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    addr_hit = (addr == offset);
  endfunction

  // writable bits only, reserved bits forced to zero
  function automatic logic [7:0] writable(input logic [7:0] value);
    writable = value & cofc_pkg::WRITABLE_MASK;
  endfunction

  // one-hot alarm reference, nothing for reserved codes
  function automatic logic [4:0] ref_onehot(input logic [2:0] code);
    case (code)
      cofc_pkg::REF_EXTERNAL: ref_onehot = 5'h01;
      cofc_pkg::REF_INPUT_1: ref_onehot = 5'h02;
      cofc_pkg::REF_INPUT_2: ref_onehot = 5'h04;
      cofc_pkg::REF_INPUT_3: ref_onehot = 5'h08;
      cofc_pkg::REF_INPUT_4: ref_onehot = 5'h10;
      default: ref_onehot = cofc_pkg::REF_ONEHOT_NONE;
    endcase
  endfunction

  // one flag widened to a count term
  function automatic logic [1:0] count_term(input logic flag);
    count_term = {1'b0, flag};
  endfunction

  // address decode
  always_comb begin
    hit_three_four = addr_hit(i_addr, cofc_pkg::OUTPUT_FORMAT_THREE_FOUR_OFFSET);
    hit_five_ref = addr_hit(i_addr, cofc_pkg::OUTPUT_FIVE_FORMAT_AND_ALARM_REF_OFFSET);
  end

  // field extraction
  always_comb begin
    out3_code = field_at(output_format_three_four, 1'b0);
    out4_code = field_at(output_format_three_four, 1'b1);
    out5_code = field_at(output_five_format_and_alarm_ref, 1'b1);
    ref_code = field_at(output_five_format_and_alarm_ref, 1'b0);
  end

  // next register values, writes to other addresses ignored
  always_comb begin
    next_output_format_three_four = output_format_three_four;
    next_output_five_format_and_alarm_ref = output_five_format_and_alarm_ref;
    if (i_write && hit_three_four) begin
      next_output_format_three_four = writable(i_wdata);
    end
    if (i_write && hit_five_ref) begin
      next_output_five_format_and_alarm_ref = writable(i_wdata);
    end
  end

  // register 6
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      output_format_three_four <= cofc_pkg::OUTPUT_FORMAT_THREE_FOUR_RESET;
    end else begin
      output_format_three_four <= next_output_format_three_four;
    end
  end

  // register 7
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      output_five_format_and_alarm_ref <= cofc_pkg::OUTPUT_FIVE_FORMAT_AND_ALARM_REF_RESET;
    end else begin
      output_five_format_and_alarm_ref <= next_output_five_format_and_alarm_ref;
    end
  end

  // read data, zero when idle or unmapped
  always_comb begin
    next_rdata = 8'h00;
    if (i_read && hit_three_four) begin
      next_rdata = writable(output_format_three_four);
    end else if (i_read && hit_five_ref) begin
      next_rdata = writable(output_five_format_and_alarm_ref);
    end
  end

  // read-back
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata <= next_rdata;
      o_rvalid <= i_read;
    end
  end

  // raw fields of register 6
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_out3_format_sel <= 3'h0;
      o_out4_format_sel <= 3'h0;
    end else begin
      o_out3_format_sel <= out3_code;
      o_out4_format_sel <= out4_code;
    end
  end

  // raw fields of register 7
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_out5_format_sel <= 3'h0;
      o_offset_alarm_ref_sel <= 3'h0;
    end else begin
      o_out5_format_sel <= out5_code;
      o_offset_alarm_ref_sel <= ref_code;
    end
  end

  // output 3 decode
  cofc_format_decode u_out3 (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_code(out3_code),
    .o_format(o_out3_format),
    .o_enabled(o_out3_enabled),
    .o_high_power(out3_hp)
  );

  // output 4 decode
  cofc_format_decode u_out4 (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_code(out4_code),
    .o_format(o_out4_format),
    .o_enabled(o_out4_enabled),
    .o_high_power(out4_hp)
  );

  // output 5 decode
  cofc_format_decode u_out5 (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_code(out5_code),
    .o_format(o_out5_format),
    .o_enabled(o_out5_enabled),
    .o_high_power(out5_hp)
  );

  // alarm reference decode, reserved codes select nothing
  always_comb begin
    next_ref_onehot = ref_onehot(ref_code);
  end

  // alarm reference outputs
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_ref_external <= 1'b0;
      o_ref_input <= 4'h0;
      o_ref_reserved <= 1'b0;
    end else begin
      o_ref_external <= next_ref_onehot[0];
      o_ref_input <= next_ref_onehot[4:1];
      o_ref_reserved <= (next_ref_onehot == cofc_pkg::REF_ONEHOT_NONE);
    end
  end

  // count of lvpecl/cmos among outputs 3-5, for software power budget checks
  always_comb begin
    next_high_power_count = count_term(out3_hp) + count_term(out4_hp) + count_term(out5_hp);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_high_power_count <= 2'h0;
    end else begin
      o_high_power_count <= next_high_power_count;
    end
  end
endmodule

// [hdl/cofc_format_decode.sv]
// cofc_format_decode: registered decode of one three-bit output format code
// assumes the code comes from a register on the same clock
`timescale 1ns/100ps
module cofc_format_decode (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // code in
  input wire logic [2:0] i_code,
  // decoded format
  output cofc_pkg::cofc_format_type o_format,
  output logic o_enabled,
  output logic o_high_power
);
  cofc_pkg::cofc_format_type next_format;

  always_comb begin
    case (i_code)
      cofc_pkg::FMT_DISABLE: next_format = cofc_pkg::COFC_FMT_DISABLED;
      cofc_pkg::FMT_CMOS: next_format = cofc_pkg::COFC_FMT_CMOS;
      cofc_pkg::FMT_LVDS_LOW: next_format = cofc_pkg::COFC_FMT_LVDS_LOW;
      cofc_pkg::FMT_LVPECL: next_format = cofc_pkg::COFC_FMT_LVPECL;
      cofc_pkg::FMT_CML: next_format = cofc_pkg::COFC_FMT_CML;
      cofc_pkg::FMT_LVDS: next_format = cofc_pkg::COFC_FMT_LVDS;
      default: next_format = cofc_pkg::COFC_FMT_RESERVED;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_format <= cofc_pkg::COFC_FMT_RESERVED;
      o_enabled <= 1'b0;
      o_high_power <= 1'b0;
    end else begin
      o_format <= next_format;
      o_enabled <= (next_format != cofc_pkg::COFC_FMT_DISABLED) && (next_format != cofc_pkg::COFC_FMT_RESERVED);
      o_high_power <= (next_format == cofc_pkg::COFC_FMT_CMOS) || (next_format == cofc_pkg::COFC_FMT_LVPECL);
    end
  end
endmodule

// [include/cofc_pkg.sv]
// cofc_pkg: offsets, field layout, reset values and codes of the output format registers
// assumes a byte-wide register port with 8-bit addresses
package cofc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OUTPUT_FORMAT_THREE_FOUR_OFFSET = 8'h06;
  localparam logic [7:0] OUTPUT_FIVE_FORMAT_AND_ALARM_REF_OFFSET = 8'h07;
  localparam logic [7:0] OUTPUT_FORMAT_THREE_FOUR_RESET = 8'h2c;
  localparam logic [7:0] OUTPUT_FIVE_FORMAT_AND_ALARM_REF_RESET = 8'h2a;
  localparam int unsigned LOW_FIELD_LSB = 0;
  localparam int unsigned HIGH_FIELD_LSB = 3;
  localparam int unsigned FIELD_W = 3;
  localparam logic [7:0] WRITABLE_MASK = 8'h3f;
  // three-bit output format codes
  localparam logic [2:0] FMT_RSVD0 = 3'h0;
  localparam logic [2:0] FMT_DISABLE = 3'h1;
  localparam logic [2:0] FMT_CMOS = 3'h2;
  localparam logic [2:0] FMT_LVDS_LOW = 3'h3;
  localparam logic [2:0] FMT_RSVD4 = 3'h4;
  localparam logic [2:0] FMT_LVPECL = 3'h5;
  localparam logic [2:0] FMT_CML = 3'h6;
  localparam logic [2:0] FMT_LVDS = 3'h7;
  // decoded format, one-hot
  typedef enum logic [6:0] {
    COFC_FMT_RESERVED = 7'b000_0001,
    COFC_FMT_DISABLED = 7'b000_0010,
    COFC_FMT_CMOS = 7'b000_0100,
    COFC_FMT_LVDS_LOW = 7'b000_1000,
    COFC_FMT_LVPECL = 7'b001_0000,
    COFC_FMT_CML = 7'b010_0000,
    COFC_FMT_LVDS = 7'b100_0000
  } cofc_format_type;
  // frequency offset alarm reference codes
  localparam logic [2:0] REF_EXTERNAL = 3'h0;
  localparam logic [2:0] REF_INPUT_1 = 3'h1;
  localparam logic [2:0] REF_INPUT_2 = 3'h2;
  localparam logic [2:0] REF_INPUT_3 = 3'h3;
  localparam logic [2:0] REF_INPUT_4 = 3'h4;
  localparam logic [4:0] REF_ONEHOT_NONE = 5'h00;
endpackage

// [testbench/cofc_config_regs_chk.sv]
// cofc_config_regs_chk: assertions on the output format register ports
// assumes it is bound to cofc_config_regs on one clock
`timescale 1ns/100ps
module cofc_config_regs_chk (
  // clock, reset and register port
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic i_write,
  input wire logic [7:0] i_wdata,
  input wire logic i_read,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  // decoded and raw fields
  input cofc_pkg::cofc_format_type o_out4_format,
  input wire logic o_out4_enabled,
  input wire logic o_ref_external,
  input wire logic [3:0] o_ref_input,
  input wire logic o_ref_reserved,
  input wire logic [2:0] o_out3_format_sel,
  input wire logic [2:0] o_out4_format_sel,
  input wire logic [2:0] o_out5_format_sel,
  input wire logic [2:0] o_offset_alarm_ref_sel,
  input wire logic [1:0] o_high_power_count
);
  localparam logic [6:0] DEC [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h01, 7'h10, 7'h20, 7'h40};
  wire logic w6 = i_write && i_addr == 8'h06;
  wire logic w7 = i_write && i_addr == 8'h07;
  wire logic [1:0] hp = {1'b0, o_out3_format_sel inside {3'h2, 3'h5}} + (o_out4_format_sel inside {3'h2, 3'h5})
    + (o_out5_format_sel inside {3'h2, 3'h5});
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  property p_out3; w6 |-> ##2 o_out3_format_sel == $past(i_wdata[2:0], 2); endproperty
  a_out3: assert property (p_out3) else $error("out3 field mismatch");
  property p_out4; w6 |-> ##2 o_out4_format_sel == $past(i_wdata[5:3], 2); endproperty
  a_out4: assert property (p_out4) else $error("out4 field mismatch");
  property p_out5; w7 |-> ##2 o_out5_format_sel == $past(i_wdata[5:3], 2); endproperty
  a_out5: assert property (p_out5) else $error("out5 field mismatch");
  property p_dec; o_out4_format == DEC[o_out4_format_sel]
    && o_out4_enabled == (DEC[o_out4_format_sel] > 7'h02); endproperty
  a_dec: assert property (p_dec) else $error("format decode mismatch");
  property p_ref; !$past(i_reset) |-> {o_ref_reserved, o_ref_input, o_ref_external} ==
    ((o_offset_alarm_ref_sel > 3'h4) ? 6'h20 : 6'(6'h01 << o_offset_alarm_ref_sel)); endproperty
  a_ref: assert property (p_ref) else $error("alarm reference decode mismatch");
  property p_unmapped; i_read && !(i_addr inside {8'h06, 8'h07}) |=> o_rvalid && o_rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rsvd; o_rvalid |-> o_rdata[7:6] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_rst; $fell(i_reset) |=>
    {o_out4_format_sel, o_out3_format_sel, o_out5_format_sel, o_offset_alarm_ref_sel} == 12'hb2a; endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_cnt; o_high_power_count == $past(hp); endproperty
  a_cnt: assert property (p_cnt) else $error("high power count wrong");
endmodule
bind cofc_config_regs cofc_config_regs_chk cofc_config_regs_chk_i (.*);

// [testbench/test_cofc_config_regs.sv]
// test_cofc_config_regs: self-checking bench for the output format registers
// assumes cofc_pkg and the bound checker are compiled first
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module test_cofc_config_regs;
  logic i_clk, i_reset, i_write, i_read, o_rvalid, o_out3_enabled, o_out4_enabled, o_out5_enabled;
  logic o_ref_external, o_ref_reserved;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [2:0] o_offset_alarm_ref_sel, o_out3_format_sel, o_out4_format_sel, o_out5_format_sel;
  logic [3:0] o_ref_input;
  logic [1:0] o_high_power_count;
  cofc_pkg::cofc_format_type o_out3_format, o_out4_format, o_out5_format;
  int failures, n_compared, m6, m7, pe, pr;
  int fb [8] = '{0, 1, 2, 3, 0, 4, 5, 6};
  cofc_config_regs cofc_config_regs_i (.*);
  initial begin
    i_clk = 0;
    forever #2 i_clk = ~i_clk;
  end
  function automatic logic [6:0] fmt(int c);
    return 7'h01 << fb[c];
  endfunction
  function automatic int hp(int c);
    return (c == 2 || c == 5) ? 1 : 0;
  endfunction
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one cycle of the register port; checks the answer to the previous cycle
  task automatic step(bit w, bit r, logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_write <= w;
    i_read <= r;
    i_addr <= a;
    i_wdata <= d;
    #1;
    if (pr) `CHK("rdata", pe, o_rdata)
    `CHK("rvalid", pr, o_rvalid)
    pr = r;
    pe = (a == 8'h06) ? m6 : (a == 8'h07) ? m7 : 0;
    if (w && a == 8'h06) m6 = d & 'h3f;
    if (w && a == 8'h07) m7 = d & 'h3f;
  endtask
  task automatic rst();
    @(posedge i_clk);
    i_reset <= 1;
    repeat (5) @(posedge i_clk);
    i_reset <= 0;
    m6 = 'h2c;
    m7 = 'h2a;
  endtask
  task automatic chkf();
    repeat (3) step(0, 0, 8'h00, 8'h00);
    `CHK("out3 sel", m6 & 7, o_out3_format_sel)
    `CHK("out4 sel", (m6 >> 3) & 7, o_out4_format_sel)
    `CHK("out5 sel", (m7 >> 3) & 7, o_out5_format_sel)
    `CHK("ref sel", m7 & 7, o_offset_alarm_ref_sel)
    `CHK("out3 fmt", fmt(m6 & 7), o_out3_format)
    `CHK("out5 fmt", fmt((m7 >> 3) & 7), o_out5_format)
    `CHK("out4 en", fb[(m6 >> 3) & 7] > 1, o_out4_enabled)
    `CHK("out4 fmt", fmt((m6 >> 3) & 7), o_out4_format)
    `CHK("out3 en", fb[m6 & 7] > 1, o_out3_enabled)
    `CHK("out5 en", fb[(m7 >> 3) & 7] > 1, o_out5_enabled)
    `CHK("ref hot", (m7 & 7) > 4 ? 'h20 : 1 << (m7 & 7), {o_ref_reserved, o_ref_input, o_ref_external})
    `CHK("count", hp(m6 & 7) + hp((m6 >> 3) & 7) + hp((m7 >> 3) & 7), o_high_power_count)
  endtask
  initial begin
    {i_reset, i_write, i_read, i_addr, i_wdata} = {1'b1, 18'h0_0000};
    void'($urandom(32'ha2b0_9566));
    rst();
    step(0, 1, 8'h06, 8'h00);
    step(0, 1, 8'h07, 8'h00);
    step(0, 1, 8'h08, 8'h00);
    chkf();
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      step(1, 0, 8'h06, 8'(c * 9) | 8'hc0);
      step(1, 1, 8'h07, 8'(c * 9) | 8'hc0);
      step(0, 1, 8'h06, 8'h00);
      chkf();
    end
    $display("test all codes done");
    repeat (80) step($urandom % 2, $urandom % 2, 8'(5 + $urandom % 4), 8'($urandom));
    chkf();
    $display("test random traffic done");
    step(1, 0, 8'h06, 8'h3f);
    chkf();
    rst();
    step(0, 1, 8'h06, 8'h00);
    chkf();
    $display("test mid-run reset done");
    finish_test();
  end
  initial begin
    #20000;
    failures++;
    finish_test();
  end
endmodule
